/* File: fast_call_map.svh */
// Constants of the fast system call register bank: addresses, fields, resets.
// Assumes the model-specific register address space is 32 bits wide.
`ifndef FAST_CALL_MAP_SVH
`define FAST_CALL_MAP_SVH

`define FC_ADDR_CODE_SELECTOR 32'h0000_0174
`define FC_ADDR_STACK_POINTER 32'h0000_0175
`define FC_ADDR_ENTRY_POINTER 32'h0000_0176

`define FC_SELECTOR_MSB 15
`define FC_SELECTOR_LSB 0
`define FC_LOW_MSB 31
`define FC_LOW_LSB 0

`define FC_RESET_LOW 32'h0000_0000
`define FC_RAZ_HIGH 32'h0000_0000

`endif

/* File: fast_call_pkg.sv */
// Types shared by the fast system call register bank.
// Assumes fast_call_map.svh is on the include path.
package fast_call_pkg;

  typedef logic [31:0] msrAddr_t;
  typedef logic [63:0] msrData_t;
  typedef logic [31:0] lowHalf_t;

  typedef enum logic [1:0] {
    SEL_CODE = 2'b00,
    SEL_STACK = 2'b01,
    SEL_ENTRY = 2'b10,
    SEL_NONE = 2'b11
  } regSel_t;

endpackage

/* File: fast_call_word.sv */
// One 32-bit read/write storage word of the register bank.
// Assumes write strobes come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "fast_call_map.svh"

module fast_call_word #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Write side
  input wire logic wrEn,
  input wire logic [WIDTH-1:0] wrData,
  // Stored value
  output logic [WIDTH-1:0] value
);

  logic [WIDTH-1:0] value_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      value_r <= WIDTH'(`FC_RESET_LOW);
    end else if (wrEn) begin
      value_r <= wrData;
    end
  end

  assign value = value_r;

endmodule
`default_nettype wire

/* File: fast_call_msr_bank.sv */
// Fast system call register bank: code selector, stack and entry pointers.
// Assumes a single-cycle model-specific register access port on core_clk.
//
// What this block does
// R1 - Code selector register at 0174h, zero reset
// R2 - Selector in bits 15:0, upper half zero
// R3 - Stack pointer register at 0175h, 32 bits
// R4 - Entry pointer register at 0176h, 32 bits
// R5 - Upper-half writes ignored; values always presented
`timescale 1ns/1ps
`default_nettype none
`include "fast_call_map.svh"

module fast_call_msr_bank
  import fast_call_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Register access port
  input wire logic msrWrEn,
  input wire logic msrRdEn,
  input wire fast_call_pkg::msrAddr_t msrAddr,
  input wire fast_call_pkg::msrData_t msrWrData,
  output fast_call_pkg::msrData_t msrRdData,
  output logic msrRdValid,
  output logic msrHit,
  // Values for the instruction logic
  output logic [15:0] codeSelector,
  output logic [31:0] codeSelectorWord,
  output fast_call_pkg::lowHalf_t stackPointer,
  output fast_call_pkg::lowHalf_t entryPointer
);

  import fast_call_pkg::*;

  regSel_t sel;
  logic [2:0] wrEnVec;
  lowHalf_t words [3];
  lowHalf_t rdLow;
  msrData_t rdData_r;
  logic rdValid_r;
  logic rdHit;

  // R1 R3 R4 address decode
  assign sel = (msrAddr == `FC_ADDR_CODE_SELECTOR) ? SEL_CODE :
               (msrAddr == `FC_ADDR_STACK_POINTER) ? SEL_STACK :
               (msrAddr == `FC_ADDR_ENTRY_POINTER) ? SEL_ENTRY : SEL_NONE;
  assign msrHit = (sel != SEL_NONE);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_word
      // R5 low half only
      assign wrEnVec[gi] = msrWrEn && (sel == regSel_t'(gi));
      fast_call_word #(.WIDTH(32)) u_word (
        .core_clk(core_clk),
        .resetn(resetn),
        .wrEn(wrEnVec[gi]),
        .wrData(msrWrData[`FC_LOW_MSB:`FC_LOW_LSB]),
        .value(words[gi])
      );
    end
  endgenerate

  assign rdLow = (sel == SEL_CODE) ? words[0] :
                 (sel == SEL_STACK) ? words[1] :
                 (sel == SEL_ENTRY) ? words[2] : `FC_RAZ_HIGH;
  assign rdHit = msrRdEn && msrHit;

  // R2 upper half reads zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdData_r <= '0;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= msrRdEn;
      rdData_r <= rdHit ? {`FC_RAZ_HIGH, rdLow} : '0;
    end
  end

  assign msrRdData = rdData_r;
  assign msrRdValid = rdValid_r;

  // R2 selector field
  assign codeSelector = words[0][`FC_SELECTOR_MSB:`FC_SELECTOR_LSB];
  assign codeSelectorWord = words[0];
  // R5 values presented continuously
  assign stackPointer = words[1];
  assign entryPointer = words[2];

  // Helper copies of the last cycle's write for the coverage points.
  logic pastWr;
  lowHalf_t pastData;
  regSel_t pastSel;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pastWr <= 1'b0;
      pastData <= '0;
      pastSel <= SEL_NONE;
    end else begin
      pastWr <= msrWrEn;
      pastData <= msrWrData[31:0];
      pastSel <= sel;
    end
  end

  // R1 code write lands
  AST_CODE_WRITE: assert property (@(posedge core_clk) disable iff (!resetn) // R1
    msrWrEn && sel == SEL_CODE |=> codeSelectorWord == $past(msrWrData[31:0]))
    else $error("Code selector write not stored.");

  // R2 selector field position
  AST_SEL_FIELD: assert property (@(posedge core_clk) disable iff (!resetn) // R2
    codeSelector == codeSelectorWord[15:0])
    else $error("Selector field not low sixteen bits.");

  // R2 upper half zero
  AST_RAZ_HIGH: assert property (@(posedge core_clk) disable iff (!resetn) // R2
    msrRdValid |-> msrRdData[63:32] == 32'h0000_0000)
    else $error("Upper half did not read as zero.");

  // R3 stack write lands
  AST_STACK_WRITE: assert property (@(posedge core_clk) disable iff (!resetn) // R3
    msrWrEn && sel == SEL_STACK |=> stackPointer == $past(msrWrData[31:0]))
    else $error("Stack pointer write not stored.");

  // R4 entry write lands
  AST_ENTRY_WRITE: assert property (@(posedge core_clk) disable iff (!resetn) // R4
    msrWrEn && sel == SEL_ENTRY |=> entryPointer == $past(msrWrData[31:0]))
    else $error("Entry pointer write not stored.");

  // R4 entry read back
  AST_ENTRY_READ: assert property (@(posedge core_clk) disable iff (!resetn) // R4
    msrRdEn && !msrWrEn && sel == SEL_ENTRY ##1 !msrWrEn
      |-> msrRdData[31:0] == entryPointer)
    else $error("Entry pointer read mismatch.");

  // R5 values hold
  AST_HOLD: assert property (@(posedge core_clk) disable iff (!resetn) // R5
    !msrWrEn |=> $stable(stackPointer) && $stable(entryPointer)
      && $stable(codeSelectorWord))
    else $error("Register changed without a write.");

  // R5 unmapped read zero
  AST_MISS_READ: assert property (@(posedge core_clk) disable iff (!resetn) // R5
    msrRdEn && !msrHit |=> msrRdValid && msrRdData == 64'h0)
    else $error("Unmapped read did not return zero.");

  // R1 code read back
  AST_CODE_READ: assert property (@(posedge core_clk) disable iff (!resetn) // R1
    msrRdEn && !msrWrEn && sel == SEL_CODE
      |=> msrRdData[31:0] == codeSelectorWord)
    else $error("Code selector read mismatch.");

  // R3 stack read back
  AST_STACK_READ: assert property (@(posedge core_clk) disable iff (!resetn) // R3
    msrRdEn && !msrWrEn && sel == SEL_STACK
      |=> msrRdData[31:0] == stackPointer)
    else $error("Stack pointer read mismatch.");

  // R1 read answer latency
  AST_RD_LATENCY: assert property (@(posedge core_clk) disable iff (!resetn) // R1
    msrRdEn |=> msrRdValid)
    else $error("Read not answered after one cycle.");

  // R1 no stray answer
  AST_NO_STRAY_VALID: assert property (@(posedge core_clk) disable iff (!resetn) // R1
    !msrRdEn |=> !msrRdValid)
    else $error("Read answer without a request.");

  // R2 idle data zero
  AST_IDLE_ZERO: assert property (@(posedge core_clk) disable iff (!resetn) // R2
    !msrRdValid |-> msrRdData == 64'h0)
    else $error("Read data not zero while idle.");

  // R1 address decode
  AST_HIT_DECODE: assert property (@(posedge core_clk) disable iff (!resetn) // R1
    msrHit == (msrAddr >= `FC_ADDR_CODE_SELECTOR
      && msrAddr <= `FC_ADDR_ENTRY_POINTER))
    else $error("Address hit decode wrong.");

  // R5 unmapped write ignored
  AST_MISS_WRITE: assert property (@(posedge core_clk) disable iff (!resetn) // R5
    msrWrEn && !msrHit |=> $stable(stackPointer) && $stable(entryPointer)
      && $stable(codeSelectorWord))
    else $error("Unmapped write changed a register.");

  // R1 code write only
  AST_CODE_ONLY: assert property (@(posedge core_clk) disable iff (!resetn) // R1
    msrWrEn && sel == SEL_CODE |=> $stable(stackPointer) && $stable(entryPointer))
    else $error("Code selector write touched another register.");

  // R3 stack write only
  AST_STACK_ONLY: assert property (@(posedge core_clk) disable iff (!resetn) // R3
    msrWrEn && sel == SEL_STACK |=> $stable(entryPointer) && $stable(codeSelectorWord))
    else $error("Stack pointer write touched another register.");

  // R4 entry write only
  AST_ENTRY_ONLY: assert property (@(posedge core_clk) disable iff (!resetn) // R4
    msrWrEn && sel == SEL_ENTRY |=> $stable(stackPointer) && $stable(codeSelectorWord))
    else $error("Entry pointer write touched another register.");

  // R1 zero during reset
  AST_RESET_ZERO: assert property (@(posedge core_clk) // R1
    !resetn |-> codeSelectorWord == 32'h0 && stackPointer == 32'h0
      && entryPointer == 32'h0 && !msrRdValid)
    else $error("Register not zero during reset.");

  // Coverage of the main access kinds.
  COV_MISS_RD: cover property (@(posedge core_clk) disable iff (!resetn)
    msrRdEn && !msrHit);
  COV_CODE_WR: cover property (@(posedge core_clk) disable iff (!resetn)
    msrWrEn && sel == SEL_CODE);
  COV_STACK_RD: cover property (@(posedge core_clk) disable iff (!resetn)
    msrRdEn && sel == SEL_STACK);
  COV_ENTRY_WR_RD: cover property (@(posedge core_clk) disable iff (!resetn)
    msrWrEn && sel == SEL_ENTRY ##1 msrRdEn && sel == SEL_ENTRY);
  COV_PAST: cover property (@(posedge core_clk) disable iff (!resetn)
    pastWr && pastSel == SEL_STACK && pastData != 32'h0);

endmodule
`default_nettype wire

/* File: fast_call_consumer.sv */
// Model of the instruction logic that takes the bank's values.
// Assumes the values are register outputs on core_clk.
`timescale 1ns/1ps
`default_nettype none
module fast_call_consumer (
  // Clock
  input wire logic core_clk,
  // Values from the bank
  input wire logic [15:0] codeSelector,
  input wire logic [31:0] stackPointer,
  input wire logic [31:0] entryPointer,
  // Entry state taken each cycle
  output logic [79:0] entryState
);
  always_ff @(posedge core_clk) begin
    entryState <= {codeSelector, stackPointer, entryPointer};
  end
endmodule
`default_nettype wire

/* File: test_fast_call_msr_bank.sv */
// Self-checking bench of the fast system call register bank.
// Assumes reads answer exactly one cycle after the request edge.
`timescale 1ns/1ps
`default_nettype none
module test_fast_call_msr_bank;
  import fast_call_pkg::*;
  logic core_clk = 1'b0;
  logic resetn;
  logic msrWrEn = 1'b0;
  logic msrRdEn = 1'b0;
  msrAddr_t msrAddr = 32'h0000_0000;
  msrData_t msrWrData = 64'h0;
  msrData_t msrRdData;
  logic msrRdValid, msrHit;
  logic [15:0] codeSelector;
  logic [31:0] codeSelectorWord;
  lowHalf_t stackPointer, entryPointer;
  logic [79:0] entryState;
  msrData_t expQ[$];
  lowHalf_t shadow[3] = '{default: 32'h0};
  lowHalf_t cur[3] = '{default: 32'h0};
  lowHalf_t prev[3] = '{default: 32'h0};
  int num_errors = 0;
  int n_tests = 0;
  always #2 core_clk = ~core_clk;
  fast_call_msr_bank i_fast_call_msr_bank(.core_clk(core_clk),
    .resetn(resetn), .msrWrEn(msrWrEn), .msrRdEn(msrRdEn),
    .msrAddr(msrAddr), .msrWrData(msrWrData), .msrRdData(msrRdData),
    .msrRdValid(msrRdValid), .msrHit(msrHit), .codeSelector(codeSelector),
    .codeSelectorWord(codeSelectorWord), .stackPointer(stackPointer),
    .entryPointer(entryPointer));
  fast_call_consumer i_fast_call_consumer(.core_clk(core_clk),
    .codeSelector(codeSelector), .stackPointer(stackPointer),
    .entryPointer(entryPointer), .entryState(entryState));
  task automatic check(input msrData_t seen, input msrData_t exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic wr, input logic rd, input msrAddr_t a,
                        input msrData_t d);
    int idx = int'(a) - 32'h174;
    logic hit = (idx >= 0) && (idx <= 2);
    @(posedge core_clk);
    msrWrEn <= wr;
    msrRdEn <= rd;
    msrAddr <= a;
    msrWrData <= d;
    if (rd) expQ.push_back(hit ? {32'h0, shadow[idx]} : 64'h0);
    if (wr && hit) shadow[idx] <= d[31:0];
  endtask
  always @(posedge core_clk) cur <= shadow;
  always @(posedge core_clk) prev <= cur;
  always @(negedge core_clk) begin
    if (resetn) begin
      if (msrRdValid === 1'b1)
        check(msrRdData, expQ.size() ? expQ.pop_front() : ~msrRdData);
      check({codeSelectorWord, stackPointer}, {cur[0], cur[1]});
      check({16'h0, codeSelector, entryPointer},
            {16'h0, cur[0][15:0], cur[2]});
      check({63'h0, msrHit}, {63'h0, msrAddr >= 32'h174
            && msrAddr <= 32'h176});
      check({48'h0, entryState[79:64]}, {48'h0, prev[0][15:0]});
      check(entryState[63:0], {prev[1], prev[2]});
    end
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    resetn <= 1'b0;
    void'($urandom(32'hb776));
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    // zero after reset, unmapped reads zero
    for (int i = 0; i < 5; i++) access(1'b0, 1'b1, 32'h173 + i, 64'h0);
    $display("reset values done");
    for (int i = 0; i < 200; i++)
      access($urandom % 2, $urandom % 2, 32'h173 + $urandom % 5,
             {$urandom, $urandom});
    $display("random traffic done");
    for (int i = 0; i < 3; i++) access(1'b0, 1'b1, 32'h174 + i, 64'h0);
    access(1'b0, 1'b0, 32'h0, 64'h0);
    for (int i = 0; i < 8 && expQ.size() > 0; i++) @(posedge core_clk);
    if (expQ.size() > 0) num_errors++;
    $display("readback done");
    summarize();
  end
endmodule
`default_nettype wire
